// ---- logic/hssc_cfg.svh ----
// Purpose: constants for the high-side switch and secondary regulator control
// Assumes: 100 MHz clock, four outputs, two timers, two pwm generators
// Notes: configuration codes are three bits per output
`ifndef HSSC_CFG_SVH
`define HSSC_CFG_SVH

`define HSSC_NUM_OUT 4
// configuration codes
`define HSSC_CFG_OFF 3'h0
`define HSSC_CFG_ON 3'h1
`define HSSC_CFG_TMR1 3'h2
`define HSSC_CFG_TMR2 3'h3
`define HSSC_CFG_PWM1 3'h4
`define HSSC_CFG_PWM2 3'h5
// reset values
`define HSSC_CFG_RST 12'h000
`define HSSC_REG_EN_RST 1'b0
// timing
`define HSSC_CLK_HZ 100000000
`define HSSC_OC_FILTER_US 16
`define HSSC_OC_FILTER_CYC (`HSSC_OC_FILTER_US * (`HSSC_CLK_HZ / 1000000))
`define HSSC_PWM_LO_HZ 200
`define HSSC_PWM_HI_HZ 400
// one pwm step is a period divided by 256
`define HSSC_PWM_STEP_LO (`HSSC_CLK_HZ / (`HSSC_PWM_LO_HZ * 256))
`define HSSC_PWM_STEP_HI (`HSSC_CLK_HZ / (`HSSC_PWM_HI_HZ * 256))

`endif

// ---- logic/hssc_pkg.sv ----
// Purpose: shared types for the high-side switch control
// Assumes: nothing beyond the constants header
// Notes: chip mode code is one-hot
package hssc_pkg;
    // chip modes as supplied by the mode controller
    typedef enum logic [4:0]
    {
        HSSC_MODE_NORMAL = 5'h01,
        HSSC_MODE_STOP = 5'h02,
        HSSC_MODE_SLEEP = 5'h04,
        HSSC_MODE_RESTART = 5'h08,
        HSSC_MODE_FAILSAFE = 5'h10
    } hssc_mode_e;

    typedef logic [2:0] hssc_code_t;
endpackage

// ---- logic/hssc_pwm_gen.sv ----
// Purpose: one 8-bit pwm generator with two period choices
// Assumes: duty 0 means always low, 255 means high 255 of 256 steps
// Notes: period restarts cleanly on frequency change
`include "hssc_cfg.svh"
module hssc_pwm_gen
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // configuration
    input wire logic [7:0] duty_i,
    input wire logic freq_hi_i,
    // output
    output logic pwm_o
);
    logic [15:0] div_reg;
    logic [7:0] step_reg;
    logic freq_hi_reg;
    logic [15:0] step_len;

    // step length from the selected period
    assign step_len = freq_hi_reg ? 16'(`HSSC_PWM_STEP_HI - 1)
                                  : 16'(`HSSC_PWM_STEP_LO - 1);

    // prescaler and step counter, restarted when the period changes
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_reg <= 16'h0000;
            step_reg <= 8'h00;
            freq_hi_reg <= 1'b0;
        end
        else if (freq_hi_reg != freq_hi_i)
        begin
            freq_hi_reg <= freq_hi_i;
            div_reg <= 16'h0000;
            step_reg <= 8'h00;
        end
        else if (div_reg >= step_len)
        begin
            div_reg <= 16'h0000;
            step_reg <= step_reg + 8'h01;
        end
        else
        begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    // compare stage, registered
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pwm_o <= 1'b0;
        else
            pwm_o <= (step_reg < duty_i);
    end
endmodule

// ---- logic/hssc_oc_filter.sv ----
// Purpose: over-current persistence filter for one output
// Assumes: raw indication synchronous to clk_i
// Notes: any drop of the indication restarts the count
`include "hssc_cfg.svh"
module hssc_oc_filter
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // indication
    input wire logic oc_raw_i,
    // qualified trip, one cycle
    output logic trip_o
);
    localparam logic [10:0] FILT_CYC = 11'(`HSSC_OC_FILTER_CYC);
    logic [10:0] cnt_reg;

    // trip only once the indication has held longer than the filter time
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= 11'h000;
            trip_o <= 1'b0;
        end
        else
        begin
            trip_o <= 1'b0;
            if (!oc_raw_i)
                cnt_reg <= 11'h000;
            else if (cnt_reg < FILT_CYC)
                cnt_reg <= cnt_reg + 11'h001;
            else
            begin
                cnt_reg <= 11'h000;
                trip_o <= 1'b1;
            end
        end
    end
endmodule

// ---- logic/hssc_top.sv ----
// Purpose: control of four high-side outputs and the secondary regulator
// Assumes: mode, supply flags and sense inputs synchronous to clk_i
// Notes: config written via cfg_wr_i; statuses cleared by write-one strobes
`include "hssc_cfg.svh"
module hssc_top
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // chip mode
    input wire hssc_pkg::hssc_mode_e mode_i,
    // output configuration write (3 bits per output)
    input wire logic cfg_wr_i,
    input wire logic [11:0] cfg_data_i,
    // pwm setup
    input wire logic [7:0] pwm_duty_a_i,
    input wire logic [7:0] pwm_duty_b_i,
    input wire logic [1:0] pwm_freq_hi_i,
    // timer levels from the internal timers
    input wire logic [1:0] timer_i,
    // supply fault handling controls
    input wire logic overvolt_shutdown_disable_i,
    input wire logic undervolt_shutdown_disable_i,
    input wire logic supply_fault_recovery_enable_i,
    // supply fault indications
    input wire logic switch_supply_overvolt_i,
    input wire logic switch_supply_undervolt_i,
    // per-output sense
    input wire logic [3:0] overcurrent_i,
    input wire logic [3:0] open_load_i,
    // status clear strobes, write one to clear
    input wire logic [3:0] oc_clr_i,
    input wire logic [3:0] ol_clr_i,
    input wire logic ov_clr_i,
    input wire logic uv_clr_i,
    // regulator enable write
    input wire logic reg_en_wr_i,
    input wire logic reg_en_i,
    // outputs
    output logic [3:0] high_side_output_o,
    output logic secondary_regulator_en_o,
    output logic [11:0] cfg_o,
    output logic [3:0] output_overcurrent_flag_o,
    output logic [3:0] output_open_load_flag_o,
    output logic switch_supply_overvolt_flag_o,
    output logic switch_supply_undervolt_flag_o,
    output logic cfg_rejected_o
);
    // ------------------------------------------------------------
    // internal signals
    // ------------------------------------------------------------
    hssc_pkg::hssc_mode_e mode_reg;
    logic [11:0] cfg_reg;
    logic [11:0] cfg_next;
    logic [3:0] oc_trip;
    logic [1:0] pwm;
    logic [3:0] drive;
    logic ov_act;
    logic uv_act;
    logic fault_act;
    logic fault_prev_reg;
    logic fault_end;
    logic enter_off;
    logic reg_en_reg;
    logic reg_latch_off_reg;

    // decode one configuration code into a drive level
    function automatic logic code_drive(input hssc_pkg::hssc_code_t code,
                                        input logic [1:0] tmr,
                                        input logic [1:0] pw);
        logic d;
        d = 1'b0;
        unique case (code)
            `HSSC_CFG_ON: d = 1'b1;
            `HSSC_CFG_TMR1: d = tmr[0];
            `HSSC_CFG_TMR2: d = tmr[1];
            `HSSC_CFG_PWM1: d = pw[0];
            `HSSC_CFG_PWM2: d = pw[1];
            default: d = 1'b0;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------
    // sub blocks
    // ------------------------------------------------------------
    hssc_pwm_gen u_pwm_a
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .duty_i(pwm_duty_a_i),
        .freq_hi_i(pwm_freq_hi_i[0]),
        .pwm_o(pwm[0])
    );

    hssc_pwm_gen u_pwm_b
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .duty_i(pwm_duty_b_i),
        .freq_hi_i(pwm_freq_hi_i[1]),
        .pwm_o(pwm[1])
    );

    genvar gi;
    generate
        for (gi = 0; gi < `HSSC_NUM_OUT; gi = gi + 1)
        begin : g_oc
            hssc_oc_filter u_filt
            (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .oc_raw_i(overcurrent_i[gi] & high_side_output_o[gi]),
                .trip_o(oc_trip[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // mode tracking and supply fault qualification
    // ------------------------------------------------------------
    // mode history catches entry into restart and fail-safe
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            mode_reg <= hssc_pkg::HSSC_MODE_NORMAL;
        else
            mode_reg <= mode_i;
    end

    assign enter_off = (mode_i != mode_reg) &&
                       (mode_i == hssc_pkg::HSSC_MODE_RESTART ||
                        mode_i == hssc_pkg::HSSC_MODE_FAILSAFE);
    assign ov_act = switch_supply_overvolt_i &
                    ~overvolt_shutdown_disable_i;
    assign uv_act = switch_supply_undervolt_i &
                    ~undervolt_shutdown_disable_i;
    assign fault_act = ov_act | uv_act;
    assign fault_end = fault_prev_reg & ~fault_act;

    // remember whether a shutdown was active to see its end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            fault_prev_reg <= 1'b0;
        else
            fault_prev_reg <= fault_act;
    end

    // ------------------------------------------------------------
    // output configuration
    // ------------------------------------------------------------
    // writes accepted in normal mode only; hardware clears win over writes
    always_comb
    begin
        cfg_next = cfg_reg;
        if (cfg_wr_i && mode_i == hssc_pkg::HSSC_MODE_NORMAL)
            cfg_next = cfg_data_i;
        if (enter_off)
            cfg_next = `HSSC_CFG_RST;
        if (fault_end && !supply_fault_recovery_enable_i)
            cfg_next = `HSSC_CFG_RST;
        for (int i = 0; i < `HSSC_NUM_OUT; i++)
        begin
            if (oc_trip[i])
                cfg_next[i*3 +: 3] = `HSSC_CFG_OFF;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cfg_reg <= `HSSC_CFG_RST;
        else
            cfg_reg <= cfg_next;
    end

    // a write outside normal mode is refused and flagged for a cycle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cfg_rejected_o <= 1'b0;
        else
            cfg_rejected_o <= cfg_wr_i &&
                              mode_i != hssc_pkg::HSSC_MODE_NORMAL;
    end

    // ------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------
    // pwm and timer levels act as soon as the code selects them
    always_comb
    begin
        for (int i = 0; i < `HSSC_NUM_OUT; i++)
            drive[i] = code_drive(cfg_reg[i*3 +: 3], timer_i, pwm);
    end

    // forced off in restart/fail-safe and during an active supply fault
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            high_side_output_o <= 4'h0;
        else if (mode_i == hssc_pkg::HSSC_MODE_RESTART ||
                 mode_i == hssc_pkg::HSSC_MODE_FAILSAFE)
            high_side_output_o <= 4'h0;
        else if (fault_act)
            high_side_output_o <= 4'h0;
        // config clears at this edge, so old codes must not drive meanwhile
        else if (fault_end && !supply_fault_recovery_enable_i)
            high_side_output_o <= 4'h0;
        else
            high_side_output_o <= drive & ~oc_trip;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cfg_o <= `HSSC_CFG_RST;
        else
            cfg_o <= cfg_next;
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // sticky; set wins over clear, clear needs the condition gone
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            output_overcurrent_flag_o <= 4'h0;
        else
            output_overcurrent_flag_o <= oc_trip |
                (output_overcurrent_flag_o &
                 ~(oc_clr_i & ~overcurrent_i));
    end

    // open load only counts while the output is on; output left alone
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            output_open_load_flag_o <= 4'h0;
        else
            output_open_load_flag_o <= (open_load_i & high_side_output_o) |
                (output_open_load_flag_o &
                 ~(ol_clr_i & ~open_load_i));
    end

    // supply fault flags are the only report for those events
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            switch_supply_overvolt_flag_o <= 1'b0;
            switch_supply_undervolt_flag_o <= 1'b0;
        end
        else
        begin
            switch_supply_overvolt_flag_o <= switch_supply_overvolt_i |
                (switch_supply_overvolt_flag_o &
                 ~(ov_clr_i & ~switch_supply_overvolt_i));
            switch_supply_undervolt_flag_o <= switch_supply_undervolt_i |
                (switch_supply_undervolt_flag_o &
                 ~(uv_clr_i & ~switch_supply_undervolt_i));
        end
    end

    // ------------------------------------------------------------
    // secondary regulator
    // ------------------------------------------------------------
    // enable setting only changes in normal mode; restart clears it
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            reg_en_reg <= `HSSC_REG_EN_RST;
        else if (mode_i == hssc_pkg::HSSC_MODE_RESTART &&
                 mode_reg != hssc_pkg::HSSC_MODE_RESTART)
            reg_en_reg <= 1'b0;
        else if (reg_en_wr_i && mode_i == hssc_pkg::HSSC_MODE_NORMAL)
            reg_en_reg <= reg_en_i;
    end

    // latch-off held until the host writes an enable again
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            reg_latch_off_reg <= 1'b0;
        else if (mode_i == hssc_pkg::HSSC_MODE_RESTART)
            reg_latch_off_reg <= 1'b1;
        else if (reg_en_wr_i && reg_en_i &&
                 mode_i == hssc_pkg::HSSC_MODE_NORMAL)
            reg_latch_off_reg <= 1'b0;
    end

    // active in normal, stop and sleep; never in fail-safe or restart
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            secondary_regulator_en_o <= 1'b0;
        else
            secondary_regulator_en_o <= reg_en_reg & ~reg_latch_off_reg &
                (mode_i == hssc_pkg::HSSC_MODE_NORMAL ||
                 mode_i == hssc_pkg::HSSC_MODE_STOP ||
                 mode_i == hssc_pkg::HSSC_MODE_SLEEP);
    end
endmodule

// ---- tb/hssc_host_model.sv ----
// Purpose: host side model writing switch and regulator settings
// Assumes: writes are taken at the edge where the strobe is high
// Notes: data lines show the inverse value once a write is over
module hssc_host_model
(
    // clock
    input wire logic clk_i,
    // settings writes
    output logic cfg_wr_o,
    output logic [11:0] cfg_data_o,
    output logic reg_en_wr_o,
    output logic reg_en_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cfg_wr_o = 1'b0;
        cfg_data_o = 12'h000;
        reg_en_wr_o = 1'b0;
        reg_en_o = 1'b0;
    end

    // one config write; caller keeps normal mode when it must stick
    task automatic wr_cfg(input logic [11:0] d);
        @(posedge clk_i);
        cfg_data_o <= d;
        cfg_wr_o <= 1'b1;
        @(posedge clk_i);
        cfg_wr_o <= 1'b0;
        cfg_data_o <= ~d;
    endtask

    // regulator setting write, taken by the top in normal mode only
    task automatic wr_reg(input logic en);
        @(posedge clk_i);
        reg_en_o <= en;
        reg_en_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_en_wr_o <= 1'b0;
        reg_en_o <= ~en;
    endtask
endmodule

// ---- tb/hssc_checker.sv ----
// Purpose: port-level assertions for the switch control top
// Assumes: one clock, asynchronous active-low reset
// Notes: filter run length is watched on output 0 only
module hssc_checker
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // inputs watched
    input wire hssc_pkg::hssc_mode_e mode_i,
    input wire logic cfg_wr_i,
    input wire logic overvolt_shutdown_disable_i,
    input wire logic undervolt_shutdown_disable_i,
    input wire logic supply_fault_recovery_enable_i,
    input wire logic switch_supply_overvolt_i,
    input wire logic switch_supply_undervolt_i,
    input wire logic [3:0] overcurrent_i,
    input wire logic [3:0] oc_clr_i,
    // outputs watched
    input wire logic [3:0] high_side_output_o,
    input wire logic secondary_regulator_en_o,
    input wire logic [11:0] cfg_o,
    input wire logic [3:0] output_overcurrent_flag_o,
    input wire logic switch_supply_overvolt_flag_o,
    input wire logic cfg_rejected_o
);
    logic [10:0] oc_run_reg;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // consecutive cycles of raw over-current, saturating
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            oc_run_reg <= 11'h000;
        else if (!overcurrent_i[0])
            oc_run_reg <= 11'h000;
        else if (oc_run_reg != 11'h7ff)
            oc_run_reg <= oc_run_reg + 11'h001;
    end

    a_dead_mode_off: assert property (mode_i inside {hssc_pkg::HSSC_MODE_RESTART,
        hssc_pkg::HSSC_MODE_FAILSAFE} |=> high_side_output_o == 4'h0)
        else $error("outputs on after restart or fail-safe");
    a_restart_cfg_clr: assert property (mode_i == hssc_pkg::HSSC_MODE_RESTART
        |=> cfg_o == 12'h000) else $error("config kept in restart");
    a_ov_off: assert property (switch_supply_overvolt_i &&
        !overvolt_shutdown_disable_i |=> high_side_output_o == 4'h0)
        else $error("outputs on in over-voltage");
    a_uv_off: assert property (switch_supply_undervolt_i &&
        !undervolt_shutdown_disable_i |=> high_side_output_o == 4'h0)
        else $error("outputs on in under-voltage");
    a_uv_end_clear: assert property ($fell(switch_supply_undervolt_i) &&
        !supply_fault_recovery_enable_i && !undervolt_shutdown_disable_i &&
        !switch_supply_overvolt_i |-> ##[1:2] cfg_o == 12'h000)
        else $error("config kept after fault without recovery");
    a_uv_end_off: assert property ($fell(switch_supply_undervolt_i) &&
        !supply_fault_recovery_enable_i && !undervolt_shutdown_disable_i &&
        !switch_supply_overvolt_i |=> high_side_output_o == 4'h0)
        else $error("outputs back on after fault without recovery");
    a_ov_flag_set: assert property (switch_supply_overvolt_i
        |=> switch_supply_overvolt_flag_o) else $error("over-voltage flag low");
    a_oc_filter_len: assert property ($rose(output_overcurrent_flag_o[0])
        |-> oc_run_reg >= 11'h640) else $error("over-current trip too early");
    a_oc_trip_off: assert property ($rose(output_overcurrent_flag_o[0])
        |-> cfg_o[2:0] == 3'h0 && !high_side_output_o[0])
        else $error("trip left output or config on");
    a_oc_sticky: assert property ($fell(output_overcurrent_flag_o[0])
        |-> $past(oc_clr_i[0])) else $error("over-current flag self-cleared");
    a_cfg_refused: assert property (cfg_wr_i &&
        mode_i != hssc_pkg::HSSC_MODE_NORMAL |=> cfg_rejected_o)
        else $error("locked write not refused");
    a_reg_failsafe: assert property (mode_i == hssc_pkg::HSSC_MODE_FAILSAFE
        |=> !secondary_regulator_en_o) else $error("regulator on in fail-safe");
endmodule

bind hssc_top hssc_checker u_chk (.clk_i, .rst_n_i, .mode_i, .cfg_wr_i,
    .overvolt_shutdown_disable_i, .undervolt_shutdown_disable_i,
    .supply_fault_recovery_enable_i, .switch_supply_overvolt_i,
    .switch_supply_undervolt_i, .overcurrent_i, .oc_clr_i,
    .high_side_output_o, .secondary_regulator_en_o, .cfg_o,
    .output_overcurrent_flag_o, .switch_supply_overvolt_flag_o,
    .cfg_rejected_o);

// ---- tb/hssc_top_tb_top.sv ----
// Purpose: self-checking bench for the switch control top
// Assumes: inputs driven on rising edges, sampled 1 ns after
// Notes: pwm step length measured at 200 Hz right after a period restart
`include "hssc_cfg.svh"
module hssc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    hssc_pkg::hssc_mode_e mode_i;
    logic cfg_wr_i, reg_en_wr_i, reg_en_i, rej, reg_on, ovf, uvf;
    logic [11:0] cfg_data_i, cfg_o;
    logic [7:0] pwm_duty_a_i, pwm_duty_b_i;
    logic [1:0] pwm_freq_hi_i, timer_i;
    logic ovd, uvd, rec, ov, uv;
    logic [3:0] oc, ol, hso, ocf, olf;
    logic [9:0] clr;
    int num_errors = 0;
    int samples_checked = 0;

    always #5 clk_i = ~clk_i;

    hssc_host_model host (.clk_i, .cfg_wr_o(cfg_wr_i),
        .cfg_data_o(cfg_data_i), .reg_en_wr_o(reg_en_wr_i),
        .reg_en_o(reg_en_i));

    hssc_top DUT (.clk_i, .rst_n_i, .mode_i, .cfg_wr_i, .cfg_data_i,
        .pwm_duty_a_i, .pwm_duty_b_i, .pwm_freq_hi_i, .timer_i,
        .overvolt_shutdown_disable_i(ovd), .undervolt_shutdown_disable_i(uvd),
        .supply_fault_recovery_enable_i(rec), .switch_supply_overvolt_i(ov),
        .switch_supply_undervolt_i(uv), .overcurrent_i(oc),
        .open_load_i(ol), .oc_clr_i(clr[9:6]), .ol_clr_i(clr[5:2]),
        .ov_clr_i(clr[1]), .uv_clr_i(clr[0]), .reg_en_wr_i, .reg_en_i,
        .high_side_output_o(hso), .secondary_regulator_en_o(reg_on),
        .cfg_o, .output_overcurrent_flag_o(ocf),
        .output_open_load_flag_o(olf), .switch_supply_overvolt_flag_o(ovf),
        .switch_supply_undervolt_flag_o(uvf), .cfg_rejected_o(rej));

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // one-cycle clear strobes: oc, ol, ov, uv
    task automatic pulse(input logic [9:0] m);
        @(posedge clk_i);
        clr <= m;
        @(posedge clk_i);
        clr <= 10'h000;
        tick(1);
    endtask

    task automatic t_sources();
        int i;
        int n;
        host.wr_cfg(12'h249);
        tick(1);
        chk(12'(hso), 12'h00f);
        host.wr_cfg({3'h5, 3'h4, 3'h3, 3'h2});
        @(posedge clk_i);
        timer_i <= 2'h1;
        tick(2);
        chk(12'(hso), 12'h001);
        timer_i <= 2'h2;
        pwm_duty_b_i <= 8'hff;
        for (i = 0; i < 1100 && hso[3] !== 1'b1; i++)
            tick(1);
        chk(12'(hso[2:0]), 12'h002);
        chk(12'(hso[3]), 12'h001);
        // restart generator a at 200 Hz with duty 0, then count one step
        pwm_freq_hi_i <= 2'h2;
        tick(1);
        pwm_duty_a_i <= 8'h01;
        n = 0;
        repeat (2100)
        begin
            tick(1);
            n += hso[2];
        end
        chk(12'(n), 12'(`HSSC_PWM_STEP_LO));
        $display("sources test done");
    endtask

    task automatic t_lock();
        host.wr_cfg(12'h249);
        host.wr_reg(1'b1);
        mode_i <= hssc_pkg::HSSC_MODE_STOP;
        host.wr_cfg(12'h000);
        #1;
        chk(12'(rej), 12'h001);
        host.wr_reg(1'b0);
        @(posedge clk_i);
        mode_i <= hssc_pkg::HSSC_MODE_SLEEP;
        tick(2);
        chk(cfg_o, 12'h249);
        chk(12'(hso), 12'h00f);
        chk(12'(reg_on), 12'h001);
        mode_i <= hssc_pkg::HSSC_MODE_NORMAL;
        $display("lock test done");
    endtask

    task automatic t_restart();
        @(posedge clk_i);
        mode_i <= hssc_pkg::HSSC_MODE_RESTART;
        tick(2);
        chk({reg_on, cfg_o[10:0]}, 12'h000);
        chk(12'(hso), 12'h000);
        mode_i <= hssc_pkg::HSSC_MODE_NORMAL;
        tick(2);
        chk(12'(reg_on), 12'h000);
        host.wr_reg(1'b1);
        tick(1);
        chk(12'(reg_on), 12'h001);
        host.wr_cfg(12'h249);
        mode_i <= hssc_pkg::HSSC_MODE_FAILSAFE;
        tick(2);
        chk({reg_on, 7'h00, hso}, 12'h000);
        mode_i <= hssc_pkg::HSSC_MODE_NORMAL;
        host.wr_reg(1'b0);
        tick(1);
        chk(12'(reg_on), 12'h000);
        $display("restart test done");
    endtask

    task automatic t_supply();
        host.wr_cfg(12'h249);
        ov <= 1'b1;
        tick(2);
        chk({ovf, uvf, 2'h0, ocf | olf, hso}, 12'h800);
        pulse(10'h002);
        chk(12'(ovf), 12'h001);
        ov <= 1'b0;
        tick(2);
        chk(12'(hso), 12'h00f);
        pulse(10'h002);
        chk(12'(ovf), 12'h000);
        rec <= 1'b0;
        uv <= 1'b1;
        tick(2);
        chk({uvf, 7'h00, hso}, 12'h800);
        uv <= 1'b0;
        tick(1);
        chk(12'(hso), 12'h000);
        tick(2);
        chk({cfg_o[10:0], hso[0]}, 12'h000);
        pulse(10'h001);
        host.wr_cfg(12'h249);
        ovd <= 1'b1;
        uvd <= 1'b1;
        ov <= 1'b1;
        uv <= 1'b1;
        tick(3);
        chk(12'(hso), 12'h00f);
        ov <= 1'b0;
        uv <= 1'b0;
        pulse(10'h003);
        ovd <= 1'b0;
        uvd <= 1'b0;
        rec <= 1'b1;
        $display("supply test done");
    endtask

    task automatic t_current();
        oc <= 4'h1;
        tick(1500);
        chk(12'(hso), 12'h00f);
        oc <= 4'h0;
        tick(1);
        oc <= 4'h1;
        tick(1590);
        chk({ocf, hso}, 12'h00f);
        tick(20);
        chk({ocf, hso}, 12'h01e);
        chk(cfg_o, 12'h248);
        pulse(10'h040);
        oc <= 4'h0;
        tick(3);
        chk(12'(ocf), 12'h001);
        pulse(10'h040);
        chk(12'(ocf), 12'h000);
        host.wr_cfg(12'h249);
        tick(1);
        chk(12'(hso), 12'h00f);
        ol <= 4'h2;
        tick(3);
        chk({olf, hso}, 12'h02f);
        ol <= 4'h0;
        tick(3);
        chk(12'(olf), 12'h002);
        pulse(10'h008);
        chk(12'(olf), 12'h000);
        $display("current test done");
    endtask

    task automatic results();
        $display("compared %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // watchdog at twenty thousand cycles, about four times the expected run
    initial
    begin
        #200000;
        num_errors++;
        results();
    end

    initial
    begin
        mode_i = hssc_pkg::HSSC_MODE_NORMAL;
        pwm_duty_a_i = 8'h00;
        pwm_duty_b_i = 8'h00;
        pwm_freq_hi_i = 2'h3;
        timer_i = 2'h0;
        ovd = 1'b0;
        uvd = 1'b0;
        rec = 1'b1;
        ov = 1'b0;
        uv = 1'b0;
        oc = 4'h0;
        ol = 4'h0;
        clr = 10'h000;
        tick(20);
        rst_n_i <= 1'b1;
        tick(1);
        chk({cfg_o[10:0], reg_on}, 12'h000);
        t_sources();
        t_lock();
        t_restart();
        t_supply();
        t_current();
        results();
    end
endmodule
